// *** rtl/efc_top.sv ***
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "efc_map.svh"

// What this block does
// - One principle-select switch chooses phase-angle measuring when clear and cosine function when set.
// - The principle-select group is writable from the front panel menu and by a serial parameter command.
// - A set blocking switch blocks its stage whenever the matching control signal is active.
// - With the bank switch clear the active bank follows the stored serial or pushbutton selection.
// - With the bank switch set the main bank is used while the control is inactive, second while active.
// - With the bank switch set any serial or pushbutton bank selection is rejected.
// - Three reset switches clear indicators, indicators plus latches, or those plus registers.
// - With the angle switch clear the basic angle comes from the function configuration setting.
// - With the angle switch set the angle is minus ninety with control inactive and zero when active.
// - Six routing groups connect each stage start or operate signal to any start and trip outputs.
// - A group checksum is the sum of weights of its set switches, one doubling up to 128.
module efc_top
   import efc_pkg::*;
#(
   parameter int NSTAGE = 3
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic      [31:0]       prdata,
   output logic                   pslverr,
   input  wire logic              ext_control_one,
   input  wire logic              ext_control_two,
   input  wire logic              remote_reset_control,
   input  wire logic              panel_principle_wr,
   input  wire logic [7:0]        panel_principle_data,
   input  wire logic              panel_bank_req,
   input  wire logic              panel_bank_second,
   input  wire logic [NSTAGE-1:0] stage_start,
   input  wire logic [NSTAGE-1:0] stage_operate,
   output logic      [NSTAGE-1:0] stage_block,
   output logic                   use_second_bank,
   output logic                   cos_phi_mode,
   output logic                   basic_angle_zero,
   output logic                   reset_indicators,
   output logic                   reset_latched,
   output logic                   reset_registers,
   output logic      [3:0]        start_out,
   output logic      [3:0]        trip_out
);

   // ****************************************************************
   // configuration storage
   // ****************************************************************
   efc_group_t     principle_select_group_r;
   efc_group_t     function_config_group_one_r;
   efc_group_t     control_input_config_group_r [3];
   efc_group_t     output_routing_group_r [2*NSTAGE];
   efc_bank_t      stored_bank_r;
   efc_bank_t      stored_bank_nxt;

   // ****************************************************************
   // control input synchronisation
   // ****************************************************************
   logic [2:0]     ctrl_raw;
   logic [2:0]     ctrl_sync;
   logic [2:0]     ctrl_prev_r;
   logic [2:0]     ctrl_rise;

   // bit k of the synced word feeds group k
   assign ctrl_raw = {remote_reset_control, ext_control_two, ext_control_one};

   // pins are asynchronous, so two flops before any use
   efc_sync #(
      .W (3)
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (ctrl_raw),
      .sync_out (ctrl_sync)
   );

   // previous level for activation edges of the reset switches
   // idle level after reset: no false edge
   always_ff @(posedge clk) begin
      if (rst) ctrl_prev_r <= 3'h0;
      else     ctrl_prev_r <= ctrl_sync;
   end

   assign ctrl_rise = ctrl_sync & ~ctrl_prev_r;

   // ****************************************************************
   // apb decode
   // ****************************************************************
   logic           apb_access;
   logic           apb_done;
   logic           apb_wr;
   logic [7:0]     wbyte;
   logic           hit_principle;
   logic           hit_func;
   logic           hit_bank;
   logic           hit_status;
   logic [2:0]     hit_cic;
   logic [5:0]     hit_route;
   logic           hit_any;

   // full compare: address aliases are unmapped
   // only pwdata[7:0] is stored
   assign apb_access    = psel & penable;
   assign apb_done      = apb_access & pready;
   assign apb_wr        = apb_done & pwrite;
   assign wbyte         = pwdata[7:0];
   assign hit_principle = (paddr == `EFC_OFS_PRINCIPLE);
   assign hit_func      = (paddr == `EFC_OFS_FUNC_CFG1);
   assign hit_bank      = (paddr == `EFC_OFS_BANK_CMD);
   assign hit_status    = (paddr == `EFC_OFS_STATUS);
   assign hit_cic       = {paddr == `EFC_OFS_CTRL_CFG3,
                           paddr == `EFC_OFS_CTRL_CFG2,
                           paddr == `EFC_OFS_CTRL_CFG1};
   assign hit_route     = {paddr == `EFC_OFS_ROUTE6, paddr == `EFC_OFS_ROUTE5,
                           paddr == `EFC_OFS_ROUTE4, paddr == `EFC_OFS_ROUTE3,
                           paddr == `EFC_OFS_ROUTE2, paddr == `EFC_OFS_ROUTE1};
   assign hit_any       = hit_principle | hit_func | hit_bank | hit_status |
                          (|hit_cic) | (|hit_route);

   // ****************************************************************
   // derived switch fields
   // ****************************************************************
   logic [2:0]        bank_sw;
   logic [2:0]        angle_sw;
   logic [2:0]        rst_ind_sw;
   logic [2:0]        rst_lat_sw;
   logic [2:0]        rst_reg_sw;
   logic [NSTAGE-1:0] block_nxt;
   logic              bank_by_input;
   logic              angle_by_input;

   // per control signal: gather its switches and its blocking mask
   for (genvar k = 0; k < 3; k++) begin : g_ctrl
      logic [NSTAGE-1:0] blk;
      assign bank_sw[k]    = control_input_config_group_r[k][`EFC_CIC_BANK_BIT];
      assign angle_sw[k]   = control_input_config_group_r[k][`EFC_CIC_ANGLE_BIT];
      assign rst_ind_sw[k] = control_input_config_group_r[k][`EFC_CIC_RST_IND_BIT];
      assign rst_lat_sw[k] = control_input_config_group_r[k][`EFC_CIC_RST_LAT_BIT];
      assign rst_reg_sw[k] = control_input_config_group_r[k][`EFC_CIC_RST_REG_BIT];
      assign blk = control_input_config_group_r[k][`EFC_CIC_BLOCK_LSB +: NSTAGE] &
                   {NSTAGE{ctrl_sync[k]}};
   end

   // any of the three controls may block a stage
   assign block_nxt = g_ctrl[0].blk | g_ctrl[1].blk | g_ctrl[2].blk;

   // only one group may hold the bank switch; an or keeps a misconfig benign
   assign bank_by_input  = |bank_sw;
   assign angle_by_input = |angle_sw;

   // ****************************************************************
   // setting bank selection
   // ****************************************************************
   logic           bank_ctrl_level;
   logic           angle_ctrl_level;
   logic           serial_bank_wr;

   // levels use synced pins only, never raw ones
   assign bank_ctrl_level  = |(bank_sw & ctrl_sync);
   assign angle_ctrl_level = |(angle_sw & ctrl_sync);
   assign serial_bank_wr   = apb_wr & hit_bank;

   // requests are dropped, not queued, while the input owns the bank
   always_comb begin
      stored_bank_nxt = stored_bank_r;
      if (!bank_by_input) begin
         if (serial_bank_wr) begin
            stored_bank_nxt = wbyte[`EFC_BANK_SECOND_BIT] ? EFC_BANK_SECOND : EFC_BANK_MAIN;
         end else if (panel_bank_req) begin
            stored_bank_nxt = panel_bank_second ? EFC_BANK_SECOND : EFC_BANK_MAIN;
         end
      end
   end

   // stored choice is kept while the input rules
   always_ff @(posedge clk) begin
      if (rst) stored_bank_r <= EFC_BANK_MAIN;
      else     stored_bank_r <= stored_bank_nxt;
   end

   // ****************************************************************
   // configuration writes
   // ****************************************************************
   // serial write wins over a panel write in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         principle_select_group_r <= `EFC_RST_PRINCIPLE;
      end else if (apb_wr && hit_principle) begin
         principle_select_group_r <= wbyte;
      end else if (panel_principle_wr) begin
         principle_select_group_r <= panel_principle_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         function_config_group_one_r <= `EFC_RST_FUNC_CFG1;
      end else if (apb_wr && hit_func) begin
         function_config_group_one_r <= wbyte;
      end
   end

   // a group acts on the cycle after its write
   // bit n-1 of each word is switch n, so the word is the checksum
   for (genvar k = 0; k < 3; k++) begin : g_cic
      always_ff @(posedge clk) begin
         if (rst)                        control_input_config_group_r[k] <= `EFC_RST_CTRL_CFG;
         else if (apb_wr && hit_cic[k])  control_input_config_group_r[k] <= wbyte;
      end
   end

   // same for routing: one word per stage signal
   for (genvar g = 0; g < 2*NSTAGE; g++) begin : g_route
      always_ff @(posedge clk) begin
         if (rst)                          output_routing_group_r[g] <= `EFC_RST_ROUTE;
         else if (apb_wr && hit_route[g])  output_routing_group_r[g] <= wbyte;
      end
   end

   // ****************************************************************
   // output routing
   // ****************************************************************
   logic [2*NSTAGE-1:0]   stage_sig;
   logic [2*NSTAGE*8-1:0] route_flat;
   logic [3:0]            start_nxt;
   logic [3:0]            trip_nxt;

   // group order: start then operate for each stage in turn
   for (genvar s = 0; s < NSTAGE; s++) begin : g_sig
      assign stage_sig[2*s]   = stage_start[s];
      assign stage_sig[2*s+1] = stage_operate[s];
      assign route_flat[(2*s)*8 +: 8]   = output_routing_group_r[2*s];
      assign route_flat[(2*s+1)*8 +: 8] = output_routing_group_r[2*s+1];
   end

   // pure logic; the output flops follow below
   efc_route #(
      .NSIG (2*NSTAGE)
   ) u_route (
      .sig       (stage_sig),
      .groups    (route_flat),
      .start_out (start_nxt),
      .trip_out  (trip_nxt)
   );

   // ****************************************************************
   // registered functional outputs
   // ****************************************************************
   logic           reset_ind_nxt;
   logic           reset_lat_nxt;
   logic           reset_reg_nxt;
   logic           angle_zero_nxt;
   logic           second_nxt;

   // each wider reset level also clears everything below it
   // one-cycle pulses on the control's rising edge
   assign reset_reg_nxt  = |(rst_reg_sw & ctrl_rise);
   assign reset_lat_nxt  = |((rst_lat_sw | rst_reg_sw) & ctrl_rise);
   assign reset_ind_nxt  = |((rst_ind_sw | rst_lat_sw | rst_reg_sw) & ctrl_rise);
   assign angle_zero_nxt = angle_by_input ? angle_ctrl_level
                         : function_config_group_one_r[`EFC_FCG_ANGLE_BIT];
   assign second_nxt     = bank_by_input ? bank_ctrl_level
                         : (stored_bank_r == EFC_BANK_SECOND);

   always_ff @(posedge clk) begin
      if (rst) begin
         stage_block      <= '0;
         use_second_bank  <= 1'b0;
         cos_phi_mode     <= 1'b0;
         basic_angle_zero <= 1'b0;
         reset_indicators <= 1'b0;
         reset_latched    <= 1'b0;
         reset_registers  <= 1'b0;
         start_out        <= 4'h0;
         trip_out         <= 4'h0;
      end else begin
         stage_block      <= block_nxt;
         use_second_bank  <= second_nxt;
         cos_phi_mode     <= principle_select_group_r[`EFC_PSG_COS_BIT];
         basic_angle_zero <= angle_zero_nxt;
         reset_indicators <= reset_ind_nxt;
         reset_latched    <= reset_lat_nxt;
         reset_registers  <= reset_reg_nxt;
         start_out        <= start_nxt;
         trip_out         <= trip_nxt;
      end
   end

   // ****************************************************************
   // apb read mux and answer
   // ****************************************************************
   logic [31:0]    rdata_nxt;
   logic [7:0]     status_word;
   logic [7:0]     route_rd;
   logic [7:0]     cic_rd;

   // status shows synced controls, active bank, angle and principle
   // status is read only; a write to it is dropped
   assign status_word = {2'h0, cos_phi_mode, basic_angle_zero, use_second_bank, ctrl_sync};

   always_comb begin
      route_rd = 8'h00;
      cic_rd   = 8'h00;
      for (int g = 0; g < 2*NSTAGE; g++) begin
         if (hit_route[g]) route_rd = output_routing_group_r[g];
      end
      for (int k = 0; k < 3; k++) begin
         if (hit_cic[k]) cic_rd = control_input_config_group_r[k];
      end
   end

   // bits above the group byte read as zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_principle)  rdata_nxt[7:0] = principle_select_group_r;
      else if (hit_func)  rdata_nxt[7:0] = function_config_group_one_r;
      else if (hit_bank)  rdata_nxt[`EFC_BANK_SECOND_BIT] = (stored_bank_r == EFC_BANK_SECOND);
      else if (hit_status) rdata_nxt[7:0] = status_word;
      else                rdata_nxt[7:0] = route_rd | cic_rd;
   end

   // one wait state: pready rises in the second access cycle
   // read data are caught a cycle early, then held
   // unmapped: pslverr with zero data
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_access & ~pready;
         pslverr <= apb_access & ~pready & ~hit_any;
         if (apb_access && !pready && !pwrite) prdata <= rdata_nxt;
      end
   end

endmodule // efc_top

// *** rtl/efc_map.svh ***
`ifndef EFC_MAP_SVH
`define EFC_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define EFC_OFS_PRINCIPLE    12'h000
`define EFC_OFS_CTRL_CFG1    12'h004
`define EFC_OFS_CTRL_CFG2    12'h008
`define EFC_OFS_CTRL_CFG3    12'h00c
`define EFC_OFS_ROUTE1       12'h010
`define EFC_OFS_ROUTE2       12'h014
`define EFC_OFS_ROUTE3       12'h018
`define EFC_OFS_ROUTE4       12'h01c
`define EFC_OFS_ROUTE5       12'h020
`define EFC_OFS_ROUTE6       12'h024
`define EFC_OFS_FUNC_CFG1    12'h028
`define EFC_OFS_BANK_CMD     12'h02c
`define EFC_OFS_STATUS       12'h030

// ****************************************************************
// field positions inside a control input config group
// ****************************************************************
`define EFC_CIC_BLOCK_LSB    0
`define EFC_CIC_BANK_BIT     3
`define EFC_CIC_RST_IND_BIT  4
`define EFC_CIC_RST_LAT_BIT  5
`define EFC_CIC_RST_REG_BIT  6
`define EFC_CIC_ANGLE_BIT    7

// ****************************************************************
// other field positions
// ****************************************************************
`define EFC_PSG_COS_BIT      0
`define EFC_FCG_ANGLE_BIT    0
`define EFC_BANK_SECOND_BIT  0

// ****************************************************************
// reset values
// ****************************************************************
`define EFC_RST_PRINCIPLE    8'h00
`define EFC_RST_CTRL_CFG     8'h00
`define EFC_RST_ROUTE        8'h00
`define EFC_RST_FUNC_CFG1    8'h00

`endif

// *** rtl/efc_pkg.sv ***
package efc_pkg;

   // active setting bank
   typedef enum logic {
      EFC_BANK_MAIN,
      EFC_BANK_SECOND
   } efc_bank_t;

   // directional measuring principle
   typedef enum logic {
      EFC_PRIN_PHASE_ANGLE,
      EFC_PRIN_COS_PHI
   } efc_principle_t;

   // one eight-switch group, switch n held in bit n-1
   typedef logic [7:0] efc_group_t;

endpackage

// *** rtl/efc_sync.sv ***
`timescale 1ns/100ps

// two flip-flop synchroniser for asynchronous pins
module efc_sync #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   // first stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule // efc_sync

// *** rtl/efc_route.sv ***
`timescale 1ns/100ps

// routing matrix: each stage signal to any start or trip output
module efc_route #(
   parameter int NSIG = 6
) (
   input  wire logic [NSIG-1:0]   sig,
   input  wire logic [NSIG*8-1:0] groups,
   output logic      [3:0]        start_out,
   output logic      [3:0]        trip_out
);

   logic [7:0] col;

   // switch bit order per group: start1, trip1, start2, trip2, ...
   for (genvar j = 0; j < 8; j++) begin : g_col
      logic [NSIG-1:0] hit;
      for (genvar i = 0; i < NSIG; i++) begin : g_sig
         assign hit[i] = sig[i] & groups[i*8+j];
      end
      assign col[j] = |hit;
   end

   assign start_out = {col[6], col[4], col[2], col[0]};
   assign trip_out  = {col[7], col[5], col[3], col[1]};

endmodule // efc_route

// *** tb/efc_chk_sva.sv ***
`timescale 1ns/100ps

// ****************************************************************
// port checker
// ****************************************************************
module efc_chk #(
   parameter int NSTAGE = 3
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              ext_control_one,
   input wire logic              ext_control_two,
   input wire logic              remote_reset_control,
   input wire logic [NSTAGE-1:0] stage_start,
   input wire logic [NSTAGE-1:0] stage_operate,
   input wire logic [NSTAGE-1:0] stage_block,
   input wire logic              use_second_bank,
   input wire logic              cos_phi_mode,
   input wire logic              basic_angle_zero,
   input wire logic              reset_indicators,
   input wire logic              reset_latched,
   input wire logic              reset_registers,
   input wire logic [3:0]        start_out,
   input wire logic [3:0]        trip_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // all control pins together; pins are synced, so quiet needs a margin of cycles
   wire logic [2:0] ctl = {ext_control_one, ext_control_two, remote_reset_control};

   a_pready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_pready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_pready_cause: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_pair: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_prdata_hold: assert property (!(psel && penable && !pwrite) |=> $stable(prdata))
      else $error("prdata moved without a read");
   a_reset_quiet: assert property ($past(rst) |-> {stage_block, use_second_bank, cos_phi_mode,
      basic_angle_zero, reset_indicators, reset_latched, reset_registers, start_out, trip_out,
      pready} == '0) else $error("outputs not clear after reset");
   a_route_quiet: assert property (stage_start == '0 && stage_operate == '0 |=>
      start_out == 4'h0 && trip_out == 4'h0) else $error("output without stage signal");
   a_ctrl_quiet: assert property ((ctl == 3'h0) [*5] |=>
      stage_block == '0 && !reset_indicators) else $error("block or reset without control");
   a_reset_nest: assert property ((reset_latched || reset_registers) |->
      reset_indicators && (reset_latched || !reset_registers))
      else $error("reset pulses not nested");
endmodule // efc_chk

bind efc_top efc_chk #(.NSTAGE(NSTAGE)) u_chk (.*);

// *** tb/efc_ctrl_model.sv ***
`timescale 1ns/100ps

// ****************************************************************
// far side: control pins and front panel
// ****************************************************************
module efc_ctrl_model (
   input  wire logic       clk,
   input  wire logic [2:0] want,
   input  wire logic       slow,
   output logic            ext_control_one,
   output logic            ext_control_two,
   output logic            remote_reset_control,
   output logic            panel_principle_wr,
   output logic [7:0]      panel_principle_data,
   output logic            panel_bank_req,
   output logic            panel_bank_second
);
   logic [2:0] lag_r = 3'h0;

   initial begin
      {ext_control_one, ext_control_two, remote_reset_control} = 3'h0;
      {panel_principle_wr, panel_bank_req, panel_bank_second} = 3'h0;
      panel_principle_data = 8'h00;
   end

   // slow mode lags a cycle, as a contact that settles late would
   always @(posedge clk) begin
      lag_r <= want;
      {ext_control_one, ext_control_two, remote_reset_control} <= slow ? lag_r : want;
   end

   // one-cycle panel pulses; data turned over once released so stale values never match
   task panel_principle(input logic [7:0] v);
      @(posedge clk);
      panel_principle_wr <= 1'b1;
      panel_principle_data <= v;
      @(posedge clk);
      panel_principle_wr <= 1'b0;
      panel_principle_data <= ~v;
   endtask

   task panel_bank(input logic sec);
      @(posedge clk);
      panel_bank_req <= 1'b1;
      panel_bank_second <= sec;
      @(posedge clk);
      panel_bank_req <= 1'b0;
      panel_bank_second <= ~sec;
   endtask
endmodule // efc_ctrl_model

// *** tb/tb.sv ***
`timescale 1ns/100ps

module tb;
   import efc_pkg::*;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, slv_err, slow = 1'b0;
   logic        ext_control_one, ext_control_two, remote_reset_control;
   logic        panel_principle_wr, panel_bank_req, panel_bank_second;
   logic [7:0]  panel_principle_data;
   logic [2:0]  want = 3'h0, stage_start = 3'h0, stage_operate = 3'h0, stage_block;
   logic        use_second_bank, cos_phi_mode, basic_angle_zero;
   logic        reset_indicators, reset_latched, reset_registers;
   logic [3:0]  start_out, trip_out;
   efc_group_t  sw [6];
   logic [7:0]  m;
   logic [5:0]  r;
   int          err_count = 0, cmp_count = 0, n1, n2, n3;

   efc_top DUT (.*);
   efc_ctrl_model u_part (.*);

   always #10 clk = ~clk;

   // ****************************************************************
   // tasks and expectations
   // ****************************************************************
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask

   task end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // apb cycle; request held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         end_of_test();
      end
   endtask

   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task rd(input logic [11:0] a, input logic [31:0] x, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, rdat, x);
   endtask

   // checksum: weights double from one for switch one
   function automatic int csum(input efc_group_t s);
      int t = 0;
      for (int n = 1; n <= 8; n++) if (s[n-1]) t += 1 << (n - 1);
      return t;
   endfunction

   // even groups carry a stage start, odd groups its operate signal
   function automatic logic [7:0] route_exp(input logic [2:0] s, input logic [2:0] o);
      logic [7:0] v = 8'h00;
      for (int k = 0; k < 6; k++) if (k[0] ? o[k/2] : s[k/2]) v |= sw[k];
      return v;
   endfunction

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      n1 = $urandom(52);
      cyc(20);
      rst <= 1'b0;
      for (int a = 0; a < 13; a++) rd(a * 4, 32'h0, "reset value");
      apb(1'b0, 12'h034, 32'h0);
      chk("unmapped err", slv_err, 1);
      chk("unmapped data", rdat, 0);
      $display("test reset done");
      wr(12'h000, 8'h01);
      cyc(3);
      chk("cos mode", cos_phi_mode, 1);
      u_part.panel_principle(8'h00);
      cyc(3);
      chk("phase mode", cos_phi_mode, 0);
      $display("test principle done");
      for (int c = 0; c < 3; c++) begin
         n1 = ($urandom & 7) | 1;
         slow <= c[0];
         wr(12'h004 + 4 * c, n1[7:0]);
         want <= 3'b100 >> c;
         cyc(6);
         chk("block on", stage_block, n1 & 7);
         want <= 3'h0;
         cyc(6);
         chk("block off", stage_block, 0);
         wr(12'h004 + 4 * c, 8'h00);
      end
      $display("test blocking done");
      wr(12'h02c, 8'h01);
      cyc(3);
      chk("serial bank", use_second_bank, 1);
      u_part.panel_bank(1'b0);
      cyc(3);
      chk("panel bank", use_second_bank, 0);
      wr(12'h02c, 8'h01);
      wr(12'h008, 8'h08);
      cyc(6);
      chk("bank ctrl off", use_second_bank, 0);
      wr(12'h02c, 8'h00);
      rd(12'h02c, 32'h1, "bank refused");
      u_part.panel_bank(1'b0);
      want <= 3'b010;
      cyc(6);
      chk("bank ctrl on", use_second_bank, 1);
      want <= 3'h0;
      cyc(6);
      chk("bank panel refused", use_second_bank, 0);
      wr(12'h008, 8'h00);
      rd(12'h02c, 32'h1, "panel refused");
      $display("test bank done");
      for (int b = 4; b < 7; b++) begin
         wr(12'h00c, 8'h01 << b);
         want <= 3'b001;
         {n1, n2, n3} = '0;
         repeat (8) begin
            @(posedge clk);
            n1 += (reset_indicators === 1'b1);
            n2 += (reset_latched === 1'b1);
            n3 += (reset_registers === 1'b1);
         end
         chk("ind pulses", n1, 1);
         chk("latch pulses", n2, b > 4);
         chk("reg pulses", n3, b == 6);
         want <= 3'h0;
         cyc(6);
      end
      wr(12'h00c, 8'h00);
      $display("test reset pulses done");
      wr(12'h028, 8'h01);
      cyc(3);
      chk("angle setting", basic_angle_zero, 1);
      want <= 3'b100;
      wr(12'h004, 8'h80);
      wr(12'h028, 8'h00);
      cyc(3);
      chk("angle ctrl on", basic_angle_zero, 1);
      want <= 3'h0;
      wr(12'h028, 8'h00);
      wr(12'h028, 8'h01);
      cyc(4);
      chk("angle ctrl off", basic_angle_zero, 0);
      wr(12'h004, 8'h00);
      $display("test angle done");
      for (int k = 0; k < 6; k++) begin
         sw[k] = (k == 5) ? 8'hff : 8'($urandom);
         wr(12'h010 + 4 * k, 8'(csum(sw[k])));
         rd(12'h010 + 4 * k, csum(sw[k]), "route group");
      end
      for (int t = 0; t < 24; t++) begin
         r = (t == 0) ? 6'h00 : (t == 1) ? 6'h3f : 6'($urandom);
         stage_start <= r[2:0];
         stage_operate <= r[5:3];
         cyc(2);
         m = route_exp(r[2:0], r[5:3]);
         chk("start out", start_out, {m[6], m[4], m[2], m[0]});
         chk("trip out", trip_out, {m[7], m[5], m[3], m[1]});
      end
      $display("test routing done");
      end_of_test();
   end
endmodule // tb
